//--- hw/dcr_regs.sv
// Purpose: control and configuration registers of the step-up converter
// Assumes: core writes over the special-function register port, one byte per strobe
// Notes: analog and adc control outputs are static fields; the analog converter and adc logic sit outside
// Operation
// - min pulse width code: none, 20 ns, 40 ns, 80 ns
// - control bit 5: 0 large switches, 1 small switches
// - control bit 3 aligns adc tracking with longest quiet interval
// - with sync on, adc sar clock derives from converter switching cycle
// - three-bit code selects target 1.8 to 3.3 volts
// - control at page 0 address 0x97, resets to 0x21
// - configuration at page 0 address 0x96, resets zero, bit 7 read-only
// - reset values give a working converter without software setup
// - configuration bits 6:5 divide system clock by 1,2,4,8
// - configuration bit 0: 0 local oscillator, 1 system clock
// - configuration bit 4: 0 inverts synced adc clock, 1 does not
// - configuration bit 1: 0 output tied to battery in sleep, 1 floats
`timescale 1ns/1ps
module dcr_regs #(
  parameter logic [7:0] page_id = dcr_pkg::dcr_page_conv
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output dcr_pkg::dcr_analog_type analog_ctl,
  output dcr_pkg::dcr_adc_type adc_ctl,
  output logic conv_clk_level,
  output logic adc_sar_clk_level
);

  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic [7:0] config_r;
  logic [7:0] config_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic sel_control;
  logic sel_config;
  logic sync_on;
  dcr_pkg::dcr_analog_type analog_r;
  dcr_pkg::dcr_analog_type analog_nxt;
  dcr_pkg::dcr_adc_type adc_r;
  dcr_pkg::dcr_adc_type adc_nxt;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [7:0] page, input logic [7:0] addr,
                                      input logic [7:0] want);
    addr_match = (page == page_id) && (addr == want);
  endfunction

  function automatic logic [3:0] min_pulse_width_cycles(input dcr_pkg::dcr_min_pulse_width_type code);
    case (code)
      dcr_pkg::dcr_min_pulse_width_none: min_pulse_width_cycles = 4'h0;
      dcr_pkg::dcr_min_pulse_width_20: min_pulse_width_cycles = 4'(dcr_pkg::dcr_min_pulse_width_20_cyc);
      dcr_pkg::dcr_min_pulse_width_40: min_pulse_width_cycles = 4'(dcr_pkg::dcr_min_pulse_width_40_cyc);
      dcr_pkg::dcr_min_pulse_width_80: min_pulse_width_cycles = 4'(dcr_pkg::dcr_min_pulse_width_80_cyc);
      default: min_pulse_width_cycles = 4'h0;
    endcase
  endfunction

  // field decode shared by the reset images and the live next-state path
  function automatic dcr_pkg::dcr_analog_type to_analog(input logic [7:0] ctl,
                                                        input logic [7:0] cfg);
    dcr_pkg::dcr_analog_type res;
    res.min_pulse_width =
      dcr_pkg::dcr_min_pulse_width_type'(ctl[dcr_pkg::dcr_ctl_min_pulse_width_lsb +: 2]);
    res.min_pulse_cycles = min_pulse_width_cycles(res.min_pulse_width);
    res.switch_size_select = ctl[dcr_pkg::dcr_ctl_swsize_bit];
    res.output_voltage_select =
      dcr_pkg::dcr_output_voltage_select_type'(ctl[dcr_pkg::dcr_ctl_output_voltage_select_lsb +: 3]);
    res.peak_current_level = cfg[dcr_pkg::dcr_cfg_peak_bit];
    res.sleep_output_float = cfg[dcr_pkg::dcr_cfg_float_bit];
    res.converter_clock_source_select = cfg[dcr_pkg::dcr_cfg_clksrc_bit];
    return res;
  endfunction

  function automatic dcr_pkg::dcr_adc_type to_adc(input logic [7:0] ctl,
                                                  input logic [7:0] cfg);
    dcr_pkg::dcr_adc_type res;
    res.sync_enable = ctl[dcr_pkg::dcr_ctl_sync_bit];
    res.track_in_quiet = ctl[dcr_pkg::dcr_ctl_sync_bit];
    res.sar_clk_from_conv = ctl[dcr_pkg::dcr_ctl_sync_bit];
    // polarity bit matters only while synchronised
    res.sar_clk_invert = ctl[dcr_pkg::dcr_ctl_sync_bit] && !cfg[dcr_pkg::dcr_cfg_adcpol_bit];
    return res;
  endfunction

  // reset images of the registered outputs, so the async reset branch assigns constants only
  localparam dcr_pkg::dcr_analog_type analog_reset =
    to_analog(dcr_pkg::dcr_control_reset, dcr_pkg::dcr_config_reset);
  localparam dcr_pkg::dcr_adc_type adc_reset =
    to_adc(dcr_pkg::dcr_control_reset, dcr_pkg::dcr_config_reset);

  assign sel_control = addr_match(sfr_page, sfr_addr, dcr_pkg::dcr_addr_control);
  assign sel_config = addr_match(sfr_page, sfr_addr, dcr_pkg::dcr_addr_config);
  assign sfr_hit = sel_control || sel_config;

  // ----------------------------------------------------------------
  // register write and read
  // ----------------------------------------------------------------
  always_comb
  begin
    control_nxt = control_r;
    config_nxt = config_r;
    if (sfr_wr && sel_control)
    begin
      // bit 4 is stored as written; software keeps it zero
      control_nxt = sfr_wdata;
    end
    if (sfr_wr && sel_config)
    begin
      config_nxt = sfr_wdata & dcr_pkg::dcr_config_wmask;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      control_r <= dcr_pkg::dcr_control_reset;
      config_r <= dcr_pkg::dcr_config_reset;
    end
    else
    begin
      control_r <= control_nxt;
      config_r <= config_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data: registered, held until the next read strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (sfr_rd)
    begin
      if (sel_control)
      begin
        rdata_nxt = control_r;
      end
      else if (sel_config)
      begin
        rdata_nxt = config_r & dcr_pkg::dcr_config_wmask;
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;

  // ----------------------------------------------------------------
  // registered static controls
  // ----------------------------------------------------------------
  // decoded from the next register values, so the fields still move on the write edge
  always_comb
  begin
    analog_nxt = to_analog(control_nxt, config_nxt);
    adc_nxt = to_adc(control_nxt, config_nxt);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      analog_r <= analog_reset;
      adc_r <= adc_reset;
    end
    else
    begin
      analog_r <= analog_nxt;
      adc_r <= adc_nxt;
    end
  end

  assign analog_ctl = analog_r;
  assign adc_ctl = adc_r;
  assign sync_on = adc_r.sync_enable;

  // ----------------------------------------------------------------
  // converter clock as seen on the system clock
  // ----------------------------------------------------------------
  dcr_clk_shaper #(
    .div_width(2)
  ) u_shaper (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .div_code(config_r[dcr_pkg::dcr_cfg_div_lsb +: 2]),
    .clk_invert(config_r[dcr_pkg::dcr_cfg_converter_clock_polarity_bit]),
    .use_sys_clk(config_r[dcr_pkg::dcr_cfg_clksrc_bit]),
    .conv_clk_level(conv_clk_level)
  );

  // ----------------------------------------------------------------
  // adc alignment
  // ----------------------------------------------------------------
  // sar clock level follows the converter clock only when synchronised; a gate on two flops,
  // since one more flop would put it a cycle behind the converter clock
  assign adc_sar_clk_level = sync_on ? (conv_clk_level ^ adc_r.sar_clk_invert) : 1'b0;

endmodule

//--- common/dcr_pkg.sv
// Purpose: constants and carrier types for the converter control register bank
// Assumes: special-function register bus with 8-bit data, page and address
// Notes: shared by the register bank, its port checks and its bench
package dcr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] dcr_page_conv = 8'h00;
  localparam logic [7:0] dcr_addr_config = 8'h96;
  localparam logic [7:0] dcr_addr_control = 8'h97;
  localparam logic [7:0] dcr_control_reset = 8'h21;
  localparam logic [7:0] dcr_config_reset = 8'h00;
  localparam logic [7:0] dcr_config_wmask = 8'h7f;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int dcr_ctl_min_pulse_width_lsb = 6;
  localparam int dcr_ctl_swsize_bit = 5;
  localparam int dcr_ctl_resv_bit = 4;
  localparam int dcr_ctl_sync_bit = 3;
  localparam int dcr_ctl_output_voltage_select_lsb = 0;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int dcr_cfg_div_lsb = 5;
  localparam int dcr_cfg_adcpol_bit = 4;
  localparam int dcr_cfg_converter_clock_polarity_bit = 3;
  localparam int dcr_cfg_peak_bit = 2;
  localparam int dcr_cfg_float_bit = 1;
  localparam int dcr_cfg_clksrc_bit = 0;

  // ----------------------------------------------------------------
  // minimum pulse width timing at 125 MHz (8 ns period)
  // ----------------------------------------------------------------
  localparam int dcr_clk_period_ns = 8;
  localparam int dcr_min_pulse_width_20_ns = 20;
  localparam int dcr_min_pulse_width_40_ns = 40;
  localparam int dcr_min_pulse_width_80_ns = 80;
  // least times round up
  localparam int dcr_min_pulse_width_20_cyc = (dcr_min_pulse_width_20_ns + dcr_clk_period_ns - 1) / dcr_clk_period_ns;
  localparam int dcr_min_pulse_width_40_cyc = (dcr_min_pulse_width_40_ns + dcr_clk_period_ns - 1) / dcr_clk_period_ns;
  localparam int dcr_min_pulse_width_80_cyc = (dcr_min_pulse_width_80_ns + dcr_clk_period_ns - 1) / dcr_clk_period_ns;

  typedef enum logic [1:0] {
    dcr_min_pulse_width_none = 2'b00,
    dcr_min_pulse_width_20 = 2'b01,
    dcr_min_pulse_width_40 = 2'b10,
    dcr_min_pulse_width_80 = 2'b11
  } dcr_min_pulse_width_type;

  typedef enum logic [2:0] {
    dcr_v1p8 = 3'b000,
    dcr_v1p9 = 3'b001,
    dcr_v2p0 = 3'b010,
    dcr_v2p1 = 3'b011,
    dcr_v2p4 = 3'b100,
    dcr_v2p7 = 3'b101,
    dcr_v3p0 = 3'b110,
    dcr_v3p3 = 3'b111
  } dcr_output_voltage_select_type;

  // static controls to the analog converter
  typedef struct packed {
    dcr_min_pulse_width_type min_pulse_width;
    logic [3:0] min_pulse_cycles;
    logic switch_size_select;
    dcr_output_voltage_select_type output_voltage_select;
    logic peak_current_level;
    logic sleep_output_float;
    logic converter_clock_source_select;
  } dcr_analog_type;

  // controls to the adc clock logic
  typedef struct packed {
    logic sync_enable;
    logic track_in_quiet;
    logic sar_clk_from_conv;
    logic sar_clk_invert;
  } dcr_adc_type;

endpackage

//--- hw/dcr_clk_shaper.sv
// Purpose: divides and inverts the system clock seen as the converter clock
// Assumes: ref_clk is the system clock; output is a registered enable-like level
// Notes: local oscillator path lives in the analog block; here it is a select only
`timescale 1ns/1ps
module dcr_clk_shaper #(
  parameter int div_width = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [div_width-1:0] div_code,
  input wire logic clk_invert,
  input wire logic use_sys_clk,
  output logic conv_clk_level
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic level_r;
  logic level_nxt;
  logic tap;

  // ----------------------------------------------------------------
  // divider: code n gives divide by 2^n, code 0 passes the clock toggle
  // ----------------------------------------------------------------
  always_comb
  begin
    count_nxt = count_r + 8'h01;
    tap = (div_code == '0) ? count_r[0] : count_r[div_code];
    // division ignored on the local oscillator, so hold the level low while the count runs on
    level_nxt = use_sys_clk ? (tap ^ clk_invert) : 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= 8'h00;
      level_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      level_r <= level_nxt;
    end
  end

  assign conv_clk_level = level_r;

endmodule

//--- dv/dcr_regs_sva.sv
// Purpose: port checks of the converter register bank
// Assumes: one clock domain, async active-low reset
// Notes: attached to every register bank by bind
`timescale 1ns/1ps
module dcr_regs_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire dcr_pkg::dcr_analog_type analog_ctl,
  input wire dcr_pkg::dcr_adc_type adc_ctl,
  input wire logic conv_clk_level,
  input wire logic adc_sar_clk_level
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr;
    sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h97;
  endsequence
  sequence s_cfg_wr;
    sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h96;
  endsequence
  a_ctl_write_lands: assert property (
    s_ctl_wr |=> {analog_ctl.min_pulse_width, analog_ctl.switch_size_select, adc_ctl.sync_enable,
    analog_ctl.output_voltage_select} == $past({sfr_wdata[7:5], sfr_wdata[3:0]}))
    else $error("control fields missed a write");
  a_cfg_write_lands: assert property (
    s_cfg_wr |=> {analog_ctl.peak_current_level, analog_ctl.sleep_output_float,
    analog_ctl.converter_clock_source_select} == $past(sfr_wdata[2:0]))
    else $error("configuration fields missed a write");
  a_cfg_top_zero: assert property (sfr_rd && sfr_addr == 8'h96 |=> !sfr_rdata[7])
    else $error("configuration top bit read as one");
  a_miss_read_zero: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_min_pulse_map: assert property (
    analog_ctl.min_pulse_cycles == 4'(16'ha530 >> (4 * analog_ctl.min_pulse_width)))
    else $error("minimum pulse cycles wrong");
  a_sync_fanout: assert property (
    {adc_ctl.track_in_quiet, adc_ctl.sar_clk_from_conv} == {2{adc_ctl.sync_enable}})
    else $error("sync controls disagree");
  a_sar_clk_gate: assert property (
    adc_sar_clk_level == (adc_ctl.sync_enable && (conv_clk_level ^ adc_ctl.sar_clk_invert)))
    else $error("adc sar clock level wrong");
  a_local_osc_quiet: assert property (
    !analog_ctl.converter_clock_source_select [*2] |-> !conv_clk_level)
    else $error("converter clock runs on local oscillator");
  a_output_voltage_select_hold: assert property (!sfr_wr |=> $stable(analog_ctl.output_voltage_select))
    else $error("voltage select moved without a write");
endmodule
bind dcr_regs dcr_regs_sva u_sva (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_page(sfr_page),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .analog_ctl(analog_ctl), .adc_ctl(adc_ctl),
  .conv_clk_level(conv_clk_level), .adc_sar_clk_level(adc_sar_clk_level));

//--- dv/tb.sv
// Purpose: self-checking bench for the converter register bank
// Assumes: read data answers one cycle after the read strobe
// Notes: reads are queued by the driver and scored by a monitor
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_page = 8'h00;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  dcr_pkg::dcr_analog_type analog_ctl;
  dcr_pkg::dcr_adc_type adc_ctl;
  logic conv_clk_level;
  logic adc_sar_clk_level;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] cyc [4] = '{8'h00, 8'h03, 8'h05, 8'h0a};
  int num_errors = 0;
  int checks_done = 0;
  dcr_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_page(sfr_page),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .analog_ctl(analog_ctl), .adc_ctl(adc_ctl),
    .conv_clk_level(conv_clk_level), .adc_sar_clk_level(adc_sar_clk_level));
  initial forever #4 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // scoring and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
  endtask
  always @(posedge ref_clk) rd_d <= sfr_rd;
  always @(negedge ref_clk)
    if (rd_d)
      check(sfr_rdata, exp_q.pop_front());
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
  initial
  begin
    logic [7:0] c;
    logic [7:0] f;
    logic [7:0] got;
    logic lv;
    logic sv;
    int n;
    int m;
    void'($urandom(32'h3749));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h97, 8'h21);
    rd(8'h96, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 32; i++)
    begin
      // software side keeps the reserved control bit clear
      c = {i[1:0], 1'($urandom), 1'b0, 1'($urandom), i[4:2]};
      f = 8'($urandom);
      wr(8'h97, c);
      wr(8'h96, f);
      wr(8'h98, 8'hff);
      rd(8'h97, c);
      rd(8'h96, f & 8'h7f);
      rd(8'h95, 8'h00);
      @(negedge ref_clk);
      got = {analog_ctl.min_pulse_width, analog_ctl.switch_size_select, 1'b0,
        adc_ctl.sync_enable, analog_ctl.output_voltage_select};
      check(got, c);
      check({4'h0, analog_ctl.min_pulse_cycles}, cyc[c[7:6]]);
      got = {4'h0, adc_ctl.sar_clk_invert, analog_ctl.peak_current_level,
        analog_ctl.sleep_output_float, analog_ctl.converter_clock_source_select};
      check(got, {4'h0, c[3] & ~f[4], f[2:0]});
      got = {6'h0, adc_ctl.track_in_quiet, adc_ctl.sar_clk_from_conv};
      check(got, {6'h0, c[3], c[3]});
      check({7'h0, sfr_hit}, 8'h00);
      n = 0;
      m = 0;
      lv = conv_clk_level;
      sv = adc_sar_clk_level;
      repeat (64)
      begin
        @(negedge ref_clk);
        n += int'(conv_clk_level !== lv);
        m += int'(adc_sar_clk_level !== sv);
        lv = conv_clk_level;
        sv = adc_sar_clk_level;
      end
      check(8'(n), f[0] ? 8'(64 >> f[6:5]) : 8'h00);
      check(8'(m), (f[0] && c[3]) ? 8'(64 >> f[6:5]) : 8'h00);
      check({7'h0, adc_sar_clk_level}, {7'h0, c[3] & (conv_clk_level ^ ~f[4])});
      $display("test %0d done", i);
    end
    sfr_page <= 8'h01;
    wr(8'h97, 8'h00);
    rd(8'h97, 8'h00);
    sfr_page <= 8'h00;
    rd(8'h97, c);
    repeat (3) @(posedge ref_clk);
    check({7'h0, sfr_hit}, 8'h01);
    $display("test page done");
    // a second reset in mid-run must bring back the working defaults
    @(negedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h97, 8'h21);
    rd(8'h96, 8'h00);
    repeat (3) @(posedge ref_clk);
    $display("test mid reset done");
    final_report();
  end
endmodule
